// ==== rtl/cpfg_top.v ====
/*
  Five-channel counter unit with PWM and FM generation and gate capture,
  reached over AXI4-Lite. Assumes aclk at 25 MHz and synchronous pins.
*/
// Implementation choices: the AXI4-Lite register port and the register addresses.
// Function
// - Five base rates, choices one to five.
// - Rates derived from 1 MHz reference only.
// - PWM frequency is base rate times fraction.
// - PWM high time set by runtime duty.
// - High-first sequence starts period high.
// - Low-first sequence starts period low.
// - Arm value at least half arms channel.
// - Disarmed channel holds configured static level.
// - Stopped application disarms; auto-arm on start.
// - FM frequency follows runtime input.
// - FM duty fixed from configuration during run.
// - Five independent channels, any function each.
// - PWM capture: period and high counters.
// - PWM capture reports relative frequency, duty.
// - Capture pairs are adjacent channel pairs.
// - FM capture uses one gated channel.
// - Each channel counter is 16 bits.
`timescale 1ns/10ps
`default_nettype none
`include "cpfg_consts.vh"

module cpfg_top #(
  parameter NCH   = 5,
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // AXI4-Lite write address
  input  wire [11:0]      s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]       s_axi_bresp_ff,
  output reg              s_axi_bvalid_ff,
  input  wire             s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]      s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]      s_axi_rdata_ff,
  output reg  [1:0]       s_axi_rresp_ff,
  output reg              s_axi_rvalid_ff,
  input  wire             s_axi_rready,
  // Counter pins
  input  wire [NCH-1:0]   gate,
  output wire [NCH-1:0]   counter_out
);

  reg  [4:0]             ref_cnt_ff;
  reg                    ref_tick_ff;
  wire [4:0]             base_tick;
  reg                    run_ff;
  reg  [`CPFG_CFG_WIDTH-1:0] cfg_ff [0:NCH-1];
  reg  [WIDTH-1:0]       per_ff [0:NCH-1];
  reg  [WIDTH-1:0]       duty_ff [0:NCH-1];
  reg  [WIDTH-1:0]       arm_ff [0:NCH-1];
  wire [WIDTH-1:0]       cap_per [0:NCH-1];
  wire [WIDTH-1:0]       cap_hi [0:NCH-1];
  wire [NCH-1:0]         armed;
  wire [NCH-1:0]         ch_tick;
  reg  [11:0]            awaddr_ff;
  reg                    aw_have_ff;
  reg  [31:0]            wdata_ff;
  reg  [3:0]             wstrb_ff;
  reg                    w_have_ff;
  reg  [31:0]            nxt_rdata;
  reg                    nxt_rerr;
  reg                    wr_err;
  integer                i;
  integer                iw;
  integer                ir;

  // Reference oscillator: aclk divided down to 1 MHz. The 5 MHz jumper
  // setting has no equivalent here.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_ff  <= 5'h00;
      ref_tick_ff <= 1'b0;
    end else if (ref_cnt_ff == `CPFG_REF_DIV - 1) begin
      ref_cnt_ff  <= 5'h00;
      ref_tick_ff <= 1'b1;
    end else begin
      ref_cnt_ff  <= ref_cnt_ff + 5'h01;
      ref_tick_ff <= 1'b0;
    end
  end

  // Decade chain gives 100 kHz, 10 kHz, 1 kHz and 100 Hz ticks.
  assign base_tick[0] = ref_tick_ff;
  genvar d;
  generate
    for (d = 0; d < 4; d = d + 1) begin : g_dec
      reg [3:0] dec_ff;
      assign base_tick[d+1] = base_tick[d] && (dec_ff == `CPFG_DECADE_LAST);
      always @(posedge aclk) begin
        if (!aresetn) begin
          dec_ff <= 4'h0;
        end else if (base_tick[d]) begin
          dec_ff <= (dec_ff == `CPFG_DECADE_LAST) ? 4'h0 : dec_ff + 4'h1;
        end
      end
    end
  endgenerate

  // Channels; capture pairs are any two adjacent instances.
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire [2:0] rate;
      assign rate = cfg_ff[g][`CPFG_CFG_RATE_LSB+2:`CPFG_CFG_RATE_LSB];
      // Rate codes outside one to five give no ticks and park the channel.
      assign ch_tick[g] = (rate >= 3'h1 && rate <= 3'h5) ?
                          base_tick[rate-3'h1] : 1'b0;
      // Without the arm option a running application arms the channel.
      assign armed[g] = run_ff && (!cfg_ff[g][`CPFG_CFG_USE_ARM] ||
                                   arm_ff[g][WIDTH-1]);
      cpfg_channel #(
        .WIDTH (WIDTH)
      ) u_ch (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .tick          (ch_tick[g]),
        .mode          (cfg_ff[g][`CPFG_CFG_MODE_LSB+2:`CPFG_CFG_MODE_LSB]),
        .low_first     (cfg_ff[g][`CPFG_CFG_LOW_FIRST]),
        .idle_high     (cfg_ff[g][`CPFG_CFG_IDLE_HIGH]),
        .armed         (armed[g]),
        .run           (run_ff),
        .period        (per_ff[g]),
        .duty          (duty_ff[g]),
        .gate          (gate[g]),
        .out_ff        (counter_out[g]),
        .cap_period_ff (cap_per[g]),
        .cap_high_ff   (cap_hi[g])
      );
    end
  endgenerate

  // Write channel: address and data are held until both have arrived.
  // Ready stays low while a response is open, which keeps one write at a time.
  assign s_axi_awready = !aw_have_ff && !s_axi_bvalid_ff;
  assign s_axi_wready  = !w_have_ff && !s_axi_bvalid_ff;
  assign s_axi_arready = !s_axi_rvalid_ff;

  // Registers are at most 16 bits wide, so only the two low strobes matter.
  function [WIDTH-1:0] merge;
    input [WIDTH-1:0] old;
    input [31:0]      data;
    input [3:0]       strb;
    begin
      merge = old;
      if (strb[0]) merge[7:0]  = data[7:0];
      if (strb[1]) merge[15:8] = data[15:8];
    end
  endfunction

  // Writes to status, capture or unmapped words are refused with an error
  // response and change nothing.
  always @* begin
    wr_err = 1'b1;
    if (awaddr_ff[1:0] == 2'h0 && awaddr_ff == `CPFG_OFS_RUN) begin
      wr_err = 1'b0;
    end
    for (iw = 0; iw < NCH; iw = iw + 1) begin
      if (awaddr_ff[11:5] == iw + 1 && awaddr_ff[1:0] == 2'h0 &&
          awaddr_ff[4:2] <= `CPFG_OFS_ARM) begin
        wr_err = 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff      <= 1'b0;
      w_have_ff       <= 1'b0;
      awaddr_ff       <= 12'h000;
      wdata_ff        <= 32'h00000000;
      wstrb_ff        <= 4'h0;
      s_axi_bvalid_ff <= 1'b0;
      s_axi_bresp_ff  <= `CPFG_RESP_OKAY;
      run_ff          <= 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
        cfg_ff[i]  <= `CPFG_RST_CFG;
        per_ff[i]  <= `CPFG_RST_PERIOD;
        duty_ff[i] <= `CPFG_RST_DUTY;
        arm_ff[i]  <= `CPFG_RST_ARM;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (s_axi_bvalid_ff && s_axi_bready) begin
        s_axi_bvalid_ff <= 1'b0;
      end
      // A write lands one cycle after both halves are held.
      if (aw_have_ff && w_have_ff && !s_axi_bvalid_ff) begin
        aw_have_ff      <= 1'b0;
        w_have_ff       <= 1'b0;
        s_axi_bvalid_ff <= 1'b1;
        s_axi_bresp_ff  <= wr_err ? `CPFG_RESP_SLVERR : `CPFG_RESP_OKAY;
        // The run bit stands for the controlling application.
        if (awaddr_ff == `CPFG_OFS_RUN && wstrb_ff[0]) begin
          run_ff <= wdata_ff[0];
        end
        for (i = 0; i < NCH; i = i + 1) begin
          if (awaddr_ff[11:5] == i + 1 && awaddr_ff[1:0] == 2'h0) begin
            case (awaddr_ff[4:2])
              `CPFG_OFS_CFG: begin
                // Mode and rate stay put while the application runs.
                if (!run_ff && wstrb_ff[0]) begin
                  cfg_ff[i][7:0] <= wdata_ff[7:0];
                end
                if (!run_ff && wstrb_ff[1]) begin
                  cfg_ff[i][`CPFG_CFG_WIDTH-1:8] <= wdata_ff[`CPFG_CFG_WIDTH-1:8];
                end
              end
              `CPFG_OFS_PERIOD: begin
                if (!(run_ff && cfg_ff[i][2:0] == `CPFG_MODE_PWM)) begin
                  per_ff[i] <= merge(per_ff[i], wdata_ff, wstrb_ff);
                end
              end
              `CPFG_OFS_DUTY: begin
                if (!(run_ff && cfg_ff[i][2:0] == `CPFG_MODE_FM)) begin
                  duty_ff[i] <= merge(duty_ff[i], wdata_ff, wstrb_ff);
                end
              end
              `CPFG_OFS_ARM: begin
                arm_ff[i] <= merge(arm_ff[i], wdata_ff, wstrb_ff);
              end
              default: begin
              end
            endcase
          end
        end
      end
    end
  end

  // Read data is decoded from the offered address, so the answer can
  // stand one cycle after the address is taken.
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_rerr  = 1'b1;
    if (s_axi_araddr == `CPFG_OFS_RUN) begin
      nxt_rdata = {31'h00000000, run_ff};
      nxt_rerr  = 1'b0;
    end else if (s_axi_araddr == `CPFG_OFS_STATUS) begin
      nxt_rdata = {21'h000000, counter_out, armed, run_ff};
      nxt_rerr  = 1'b0;
    end
    for (ir = 0; ir < NCH; ir = ir + 1) begin
      if (s_axi_araddr[11:5] == ir + 1 && s_axi_araddr[1:0] == 2'h0) begin
        nxt_rerr = 1'b0;
        case (s_axi_araddr[4:2])
          `CPFG_OFS_CFG:        nxt_rdata = {21'h000000, cfg_ff[ir]};
          `CPFG_OFS_PERIOD:     nxt_rdata = {16'h0000, per_ff[ir]};
          `CPFG_OFS_DUTY:       nxt_rdata = {16'h0000, duty_ff[ir]};
          `CPFG_OFS_ARM:        nxt_rdata = {16'h0000, arm_ff[ir]};
          `CPFG_OFS_CAP_PERIOD: nxt_rdata = {16'h0000, cap_per[ir]};
          `CPFG_OFS_CAP_HIGH:   nxt_rdata = {16'h0000, cap_hi[ir]};
          default:              nxt_rerr  = 1'b1;
        endcase
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid_ff <= 1'b0;
      s_axi_rdata_ff  <= 32'h00000000;
      s_axi_rresp_ff  <= `CPFG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid_ff <= 1'b1;
      s_axi_rdata_ff  <= nxt_rdata;
      s_axi_rresp_ff  <= nxt_rerr ? `CPFG_RESP_SLVERR : `CPFG_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid_ff <= 1'b0;
    end
  end

endmodule // cpfg_top

`default_nettype wire

// ==== rtl/cpfg_consts.vh ====
/*
  Constants of the counter unit: register offsets, field positions,
  reset values and clock timing. Assumes inclusion by bare name.
*/
`ifndef CPFG_CONSTS_VH
`define CPFG_CONSTS_VH

// Clock timing.
`define CPFG_ACLK_PERIOD_NS   40
`define CPFG_REF_PERIOD_NS    1000
`define CPFG_REF_DIV          (`CPFG_REF_PERIOD_NS / `CPFG_ACLK_PERIOD_NS)
`define CPFG_DECADE_LAST      4'h9

// Global registers.
`define CPFG_OFS_RUN          12'h000
`define CPFG_OFS_STATUS       12'h004
// Channel c (0..4) window starts at (c + 1) * stride.
`define CPFG_CH_STRIDE        12'h020
`define CPFG_OFS_CFG          3'h0
`define CPFG_OFS_PERIOD       3'h1
`define CPFG_OFS_DUTY         3'h2
`define CPFG_OFS_ARM          3'h3
`define CPFG_OFS_CAP_PERIOD   3'h4
`define CPFG_OFS_CAP_HIGH     3'h5

// Channel configuration fields.
`define CPFG_CFG_MODE_LSB     0
`define CPFG_CFG_RATE_LSB     4
`define CPFG_CFG_LOW_FIRST    8
`define CPFG_CFG_IDLE_HIGH    9
`define CPFG_CFG_USE_ARM      10
`define CPFG_CFG_WIDTH        11

// Channel modes.
`define CPFG_MODE_OFF         3'h0
`define CPFG_MODE_PWM         3'h1
`define CPFG_MODE_FM          3'h2
`define CPFG_MODE_CAPTURE     3'h3

// Reset values.
`define CPFG_RST_CFG          11'h000
`define CPFG_RST_PERIOD       16'h0002
`define CPFG_RST_DUTY         16'h8000
`define CPFG_RST_ARM          16'h0000
`define CPFG_MIN_PERIOD       16'h0002

// Bus answers.
`define CPFG_RESP_OKAY        2'h0
`define CPFG_RESP_SLVERR      2'h2

`endif

// ==== rtl/cpfg_channel.v ====
/*
  One 16-bit counter channel: square-wave generator and gate capture.
  Assumes a one-cycle base-rate tick and a gate synchronous to aclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cpfg_consts.vh"

module cpfg_channel #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Control
  input  wire             tick,
  input  wire [2:0]       mode,
  input  wire             low_first,
  input  wire             idle_high,
  input  wire             armed,
  input  wire             run,
  input  wire [WIDTH-1:0] period,
  input  wire [WIDTH-1:0] duty,
  // Pins
  input  wire             gate,
  output reg              out_ff,
  // Capture results
  output reg  [WIDTH-1:0] cap_period_ff,
  output reg  [WIDTH-1:0] cap_high_ff
);

  reg  [WIDTH-1:0]   cnt_ff;
  reg  [WIDTH-1:0]   per_l_ff;
  reg  [WIDTH-1:0]   hi_l_ff;
  reg                gate_q_ff;
  reg                seen_ff;
  reg  [WIDTH-1:0]   per_cnt_ff;
  reg  [WIDTH-1:0]   hi_cnt_ff;
  wire [2*WIDTH-1:0] prod;
  wire [WIDTH-1:0]   hi_new;
  wire [WIDTH-1:0]   per_eff;
  wire               gen;
  wire               cap_en;
  wire               rise;
  wire               fall;
  wire [WIDTH-1:0]   ones;

  assign ones    = {WIDTH{1'b1}};
  // High time is the duty fraction of the period.
  assign prod    = period * duty;
  assign hi_new  = prod[2*WIDTH-1:WIDTH];
  // A relative frequency below one means at least two ticks per period.
  assign per_eff = (period < `CPFG_MIN_PERIOD) ? `CPFG_MIN_PERIOD : period;
  assign gen     = (mode == `CPFG_MODE_PWM) || (mode == `CPFG_MODE_FM);
  assign cap_en  = (mode == `CPFG_MODE_CAPTURE) && run;
  assign rise    = gate & ~gate_q_ff;
  assign fall    = ~gate & gate_q_ff;

  // New period and duty are taken only at a period boundary or while the channel
  // is disarmed or not generating, so a host update never cuts a phase short.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff   <= {WIDTH{1'b0}};
      per_l_ff <= `CPFG_MIN_PERIOD;
      hi_l_ff  <= {WIDTH{1'b0}};
      out_ff   <= 1'b0;
    end else if (!gen || !armed) begin
      cnt_ff   <= {WIDTH{1'b0}};
      per_l_ff <= per_eff;
      hi_l_ff  <= hi_new;
      out_ff   <= idle_high;
    end else begin
      if (low_first) begin
        out_ff <= (cnt_ff >= per_l_ff - hi_l_ff);
      end else begin
        out_ff <= (cnt_ff < hi_l_ff);
      end
      if (tick) begin
        if (cnt_ff >= per_l_ff - 1'b1) begin
          cnt_ff   <= {WIDTH{1'b0}};
          per_l_ff <= per_eff;
          hi_l_ff  <= hi_new;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

  // Counters saturate rather than wrap, so a too-slow input reads as the
  // largest value instead of a short false period.
  always @(posedge aclk) begin
    if (!aresetn) begin
      gate_q_ff     <= 1'b0;
      seen_ff       <= 1'b0;
      per_cnt_ff    <= {WIDTH{1'b0}};
      hi_cnt_ff     <= {WIDTH{1'b0}};
      cap_period_ff <= {WIDTH{1'b0}};
      cap_high_ff   <= {WIDTH{1'b0}};
    end else begin
      gate_q_ff <= gate;
      if (!cap_en) begin
        seen_ff    <= 1'b0;
        per_cnt_ff <= {WIDTH{1'b0}};
        hi_cnt_ff  <= {WIDTH{1'b0}};
      end else begin
        if (rise) begin
          seen_ff    <= 1'b1;
          // A tick in the edge cycle opens the new period, so none is lost.
          per_cnt_ff <= {{(WIDTH-1){1'b0}}, tick};
          if (seen_ff) begin
            cap_period_ff <= per_cnt_ff;
          end
        end else if (tick && per_cnt_ff != ones) begin
          per_cnt_ff <= per_cnt_ff + 1'b1;
        end
        if (fall) begin
          hi_cnt_ff <= {WIDTH{1'b0}};
          if (seen_ff) begin
            cap_high_ff <= hi_cnt_ff;
          end
        end else if (gate && tick && hi_cnt_ff != ones) begin
          hi_cnt_ff <= hi_cnt_ff + 1'b1;
        end
      end
    end
  end

endmodule // cpfg_channel

`default_nettype wire

// ==== bench/cpfg_props.sv ====
/* Port checker of the counter unit, bound into cpfg_top.
   Assumes every accepted write is visible on the AXI4-Lite ports. */
`timescale 1ns/10ps
`default_nettype none
`include "cpfg_consts.vh"

module cpfg_props #(
  parameter NCH = 5
) (
  // Clock and reset
  input wire           aclk,
  input wire           aresetn,
  // Write channels
  input wire [11:0]    s_axi_awaddr,
  input wire           s_axi_awvalid,
  input wire           s_axi_awready,
  input wire [31:0]    s_axi_wdata,
  input wire           s_axi_wvalid,
  input wire           s_axi_wready,
  input wire [1:0]     s_axi_bresp_ff,
  input wire           s_axi_bvalid_ff,
  input wire           s_axi_bready,
  // Read channels
  input wire [11:0]    s_axi_araddr,
  input wire           s_axi_arvalid,
  input wire           s_axi_arready,
  input wire [31:0]    s_axi_rdata_ff,
  input wire [1:0]     s_axi_rresp_ff,
  input wire           s_axi_rvalid_ff,
  input wire           s_axi_rready,
  // Pins
  input wire [NCH-1:0] counter_out
);
  reg [11:0]    wa_ff;
  reg [11:0]    ra_ff;
  reg [31:0]    wd_ff;
  reg           run_ff;
  reg [2:0]     quiet_ff;
  reg [10:0]    cfg_ff [0:NCH-1];
  reg [NCH-1:0] idle_v;
  reg [NCH-1:0] free_v;
  integer       i;
  integer       j;
  wire          ok_w = s_axi_bvalid_ff && s_axi_bready && s_axi_bresp_ff == `CPFG_RESP_OKAY;

  // Pins are judged only after seven quiet cycles, since the write pipeline depth is hidden.
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= 1'b0;
      quiet_ff <= 3'h0;
      for (i = 0; i < NCH; i = i + 1)
        cfg_ff[i] <= `CPFG_RST_CFG;
    end else begin
      if (s_axi_awvalid && s_axi_awready)
        wa_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        wd_ff <= s_axi_wdata;
      if (s_axi_arvalid && s_axi_arready)
        ra_ff <= s_axi_araddr;
      if (quiet_ff != 3'h7)
        quiet_ff <= quiet_ff + 3'h1;
      if (s_axi_bvalid_ff)
        quiet_ff <= 3'h0;
      if (ok_w) begin
        if (wa_ff == `CPFG_OFS_RUN)
          run_ff <= wd_ff[0];
        else if (!run_ff && wa_ff[4:0] == 5'h00 && wa_ff >= 12'h020 && wa_ff < 12'h0C0)
          cfg_ff[wa_ff[11:5] - 7'h01] <= wd_ff[10:0];
      end
    end
  end

  always @* begin
    for (j = 0; j < NCH; j = j + 1) begin
      idle_v[j] = cfg_ff[j][`CPFG_CFG_IDLE_HIGH];
      free_v[j] = run_ff && (cfg_ff[j][2:0] == `CPFG_MODE_PWM
                  || cfg_ff[j][2:0] == `CPFG_MODE_FM || cfg_ff[j][`CPFG_CFG_USE_ARM]);
    end
  end

  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_idle;
    quiet_ff == 3'h7 |-> ((counter_out ^ idle_v) & ~free_v) == '0;
  endproperty
  property p_bhold;
    s_axi_bvalid_ff && !s_axi_bready |=> s_axi_bvalid_ff && $stable(s_axi_bresp_ff);
  endproperty
  property p_rhold;
    s_axi_rvalid_ff && !s_axi_rready |=> s_axi_rvalid_ff && $stable(s_axi_rdata_ff);
  endproperty
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid_ff && ra_ff == $past(s_axi_araddr);
  endproperty
  property p_wblk;
    s_axi_bvalid_ff |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rblk;
    s_axi_rvalid_ff |-> !s_axi_arready;
  endproperty
  property p_unmap;
    s_axi_rvalid_ff && (ra_ff >= 12'h0C0 || ra_ff[1:0] != 2'h0)
      |-> s_axi_rresp_ff == `CPFG_RESP_SLVERR && s_axi_rdata_ff == 32'h0;
  endproperty
  property p_upper;
    s_axi_rvalid_ff |-> s_axi_rdata_ff[31:16] == 16'h0;
  endproperty

  a_idle: assert property (p_idle) else $error("idle pin level wrong");
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  a_rans: assert property (p_rans) else $error("read answer late");
  a_wblk: assert property (p_wblk) else $error("write taken while answer open");
  a_rblk: assert property (p_rblk) else $error("read taken while answer open");
  a_unmap: assert property (p_unmap) else $error("bad address not refused");
  a_upper: assert property (p_upper) else $error("upper read bits set");

  c_start: cover property ($rose(run_ff));
  c_err: cover property (s_axi_bvalid_ff && s_axi_bresp_ff == `CPFG_RESP_SLVERR);
  c_gen: cover property (run_ff && $rose(counter_out[0]));
endmodule // cpfg_props

bind cpfg_top cpfg_props #(.NCH(NCH)) u_props (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp_ff(s_axi_bresp_ff), .s_axi_bvalid_ff(s_axi_bvalid_ff),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata_ff(s_axi_rdata_ff), .s_axi_rresp_ff(s_axi_rresp_ff),
  .s_axi_rvalid_ff(s_axi_rvalid_ff), .s_axi_rready(s_axi_rready),
  .counter_out(counter_out)
);
`default_nettype wire

// ==== bench/cpfg_gate_src.sv ====
/* External square-wave source on the gate pins.
   Assumes the bench sets its phase lengths in aclk cycles. */
`timescale 1ns/10ps
`default_nettype none

module cpfg_gate_src #(
  parameter N = 5
) (
  // Clock
  input  wire logic         aclk,
  // Pattern
  input  wire logic         en,
  input  wire logic [15:0]  hi_cyc,
  input  wire logic [15:0]  lo_cyc,
  // Gate pins
  output wire logic [N-1:0] gate
);
  logic [N-1:0] g_ff = '0;
  logic [15:0]  cnt_ff = 16'h0000;

  // One source drives every gate, which is the parallel wiring a capture pair needs.
  assign gate = g_ff;
  always @(posedge aclk) begin
    if (!en) begin
      g_ff <= '0;
      cnt_ff <= 16'h0000;
    end else if (cnt_ff + 16'h0001 >= (g_ff[0] ? hi_cyc : lo_cyc)) begin
      g_ff <= ~g_ff;
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule // cpfg_gate_src
`default_nettype wire

// ==== bench/counter_pwm_fm_gen_capture_bench.sv ====
/* Self-checking bench of the counter unit with a register model.
   Assumes cpfg_top, its bound checker and the gate source. */
`timescale 1ns/10ps
`default_nettype none
`include "cpfg_consts.vh"

module counter_pwm_fm_gen_capture_bench;
  localparam int TK = `CPFG_REF_DIV;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awa = 12'h000;
  logic [11:0] ara = 12'h000;
  logic [31:0] wd = 32'h0;
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [1:0]  bresp, rresp;
  logic        awr, wr_rdy, bv, arr, rv;
  logic [31:0] rdata;
  logic [4:0]  gate, cout;
  logic        g_en = 0;
  logic [15:0] g_hi = 16'h0001;
  logic [15:0] g_lo = 16'h0001;
  int          fail_count = 0;
  int          n_checks = 0;
  int          regs [int];

  always #20 aclk = ~aclk;

  cpfg_top uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp_ff(bresp), .s_axi_bvalid_ff(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata_ff(rdata),
    .s_axi_rresp_ff(rresp), .s_axi_rvalid_ff(rv), .s_axi_rready(rr),
    .gate(gate), .counter_out(cout)
  );
  cpfg_gate_src src (.aclk(aclk), .en(g_en), .hi_cyc(g_hi), .lo_cyc(g_lo), .gate(gate));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang();
    chk("wait", 0, 1);
    summarize();
  endtask

  function automatic logic [31:0] rm(input int a);
    return regs.exists(a) ? regs[a] : 0;
  endfunction

  // The model drops control writes that the running state locks out.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n, dl, cf;
    dl = $urandom % 4;
    cf = rm({a[11:5], 5'h00});
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
      if (n == dl) br <= 1;
      if (bv && br) break;
    end
    br <= 0;
    if (n == 40) hang();
    chk("bresp", bresp, regs.exists(a) ? `CPFG_RESP_OKAY : `CPFG_RESP_SLVERR);
    if (!regs.exists(a)) return;
    if (a == `CPFG_OFS_RUN) regs[a] = d & 1;
    else if (a[4:0] == 0) begin
      if (!regs[0]) regs[a] = d & 32'h7FF;
    end else if (a[4:0] == 4) begin
      if (!(regs[0] && cf[2:0] == `CPFG_MODE_PWM)) regs[a] = d & 32'hFFFF;
    end else if (a[4:0] == 8) begin
      if (!(regs[0] && cf[2:0] == `CPFG_MODE_FM)) regs[a] = d & 32'hFFFF;
    end else regs[a] = d & 32'hFFFF;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    int n, dl;
    dl = $urandom % 4;
    @(posedge aclk);
    ara <= a;
    arv <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arr) arv <= 0;
      if (n == dl) rr <= 1;
      if (rv && rr) break;
    end
    rr <= 0;
    if (n == 40) hang();
    chk("rresp", rresp, regs.exists(a) ? `CPFG_RESP_OKAY : `CPFG_RESP_SLVERR);
    chk($sformatf("rd %h", a), rdata, e);
  endtask

  task automatic wl(input int c, input logic v, output int n);
    for (n = 0; n < 3000 && cout[c] !== v; n++) @(posedge aclk);
    if (n == 3000) hang();
  endtask

  // The first period after a change may be a mix, so the third whole one is judged.
  task automatic pwm(input int c, input int p, input int d, input int t);
    int k, hi, lo;
    for (k = 0; k < 2; k++) begin
      wl(c, 0, hi);
      wl(c, 1, hi);
      wl(c, 0, hi);
      wl(c, 1, lo);
    end
    chk($sformatf("high %0d", c), hi, ((p * d) >> 16) * t);
    chk($sformatf("period %0d", c), hi + lo, p * t);
  endtask

  task automatic hold(input int c);
    int n, k;
    k = 0;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (cout[c] !== 1'b1) k++;
    end
    chk("hold", k, 0);
  endtask

  initial begin
    int a, n, h, l;
    void'($urandom(57));
    regs[0] = 0;
    regs[4] = 0;
    for (a = 32'h20; a < 32'hC0; a += 32'h20) begin
      regs[a] = `CPFG_RST_CFG;
      regs[a + 4] = `CPFG_RST_PERIOD;
      regs[a + 8] = `CPFG_RST_DUTY;
      regs[a + 12] = `CPFG_RST_ARM;
      regs[a + 16] = 0;
      regs[a + 20] = 0;
    end
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    for (a = 0; a < 32'hC0; a += 4)
      if (a != 4 && a[4:0] < 16) rd(12'(a), rm(a));
    rd(12'h038, 0);
    rd(12'h002, 0);
    rd(12'hFFC, 0);
    wr(12'h0C0, 1);
    wr(12'h022, 1);
    wr(12'h020, 32'h011);
    wr(12'h024, 4);
    wr(12'h028, 32'h4000);
    wr(12'h040, 32'h111);
    wr(12'h044, 5);
    wr(12'h060, 32'h012);
    wr(12'h068, 32'h4000);
    wr(12'h064, 4);
    wr(12'h080, 32'h611);
    wr(12'h084, 4);
    wr(12'h0A0, 32'h021);
    wr(12'h0A4, 2);
    wr(12'h000, 1);
    wl(0, 1, n);
    chk("first0", n <= 3, 1);
    wl(1, 1, n);
    chk("first1", n >= 40 && n <= 80, 1);
    pwm(0, 4, 32'h4000, TK);
    pwm(1, 5, 32'h8000, TK);
    pwm(2, 4, 32'h4000, TK);
    pwm(4, 2, 32'h8000, 10 * TK);
    wr(12'h028, 32'hC000);
    pwm(0, 4, 32'hC000, TK);
    wr(12'h024, 8);
    wr(12'h020, 0);
    rd(12'h024, rm(12'h024));
    rd(12'h020, rm(12'h020));
    wr(12'h064, 8);
    wr(12'h068, 32'hC000);
    rd(12'h068, rm(12'h068));
    pwm(2, 8, 32'h4000, TK);
    hold(3);
    wr(12'h08C, 32'h7FFF);
    hold(3);
    wr(12'h08C, 32'h8000);
    pwm(3, 4, 32'h8000, TK);
    wr(12'h000, 0);
    repeat (8) @(posedge aclk);
    chk("stopped", cout, 5'h08);
    rd(12'h004, 32'h200);
    h = 1 + $urandom % 6;
    l = 1 + $urandom % 6;
    wr(12'h080, 32'h013);
    wr(12'h0A0, 32'h013);
    g_hi <= 16'(h * TK);
    g_lo <= 16'(l * TK);
    g_en <= 1;
    wr(12'h000, 1);
    repeat ((h + l) * TK * 4) @(posedge aclk);
    rd(12'h090, h + l);
    rd(12'h0B4, h);
    rd(12'h0B0, h + l);
    summarize();
  end

  initial begin
    repeat (100000) @(posedge aclk);
    hang();
  end
endmodule // counter_pwm_fm_gen_capture_bench
`default_nettype wire
